// *** core/gate_driver_spi_slave_crc.sv ***
// Serial slave of the bridge gate driver: frame checking and reply building.
// Assumes an external master makes select and shift clock; the user side
// supplies the live status payload and consumes decoded command payloads.
//
// How it works
// - Every transfer is one 24-bit frame from master to this slave.
// - Output enable follows select, so the data line floats when unselected.
// - Received bits never reach the output; replies are built separately.
// - Separate 24-bit receive and transmit shift registers.
// - Most significant bit goes first in both directions.
// - Input data sampled on shift clock rising edges.
// - Transmit register advances on shift clock falling edges.
// - A received frame acts only after select returns high.
// - Frames with a communication error are never decoded.
// - Reply status is sampled live up to two cycles into each frame.
// - Each reply carries a check code over its other bits.
// - Incoming check code verified over the whole frame; mismatch is an error.
// - Check code uses polynomial x^3+x+1 on both sides.
// - Check register seeded 101, giving start value 100.
// - Select low enables shifting; select high holds the shifter idle.
`timescale 1ns/1ps
module gate_driver_spi_slave_crc (
    // System clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Serial link pins
    input wire logic shiftClock,
    input wire logic frameSelectLow,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOe,
    // Reply payload, live status from the core
    input wire logic [gd_spi_pkg::PAYLOAD_BITS-1:0] txPayload,
    // Decoded command payload
    output logic rxValid,
    output logic [gd_spi_pkg::PAYLOAD_BITS-1:0] rxPayload,
    // Communication error, one pulse per bad frame
    output logic commError
);
    import gd_spi_pkg::*;

    // ========================================================================
    // System-domain state
    // ========================================================================
    typedef struct packed {
        logic selMeta;
        logic selSync;
        logic selPrev;
        logic frameMeta;
        logic frameSync;
        logic frameSeen;
        logic extraMeta;
        logic extraSync;
        logic extraSeen;
        logic [FRAME_BITS-1:0] txHeld;
        logic valid;
        logic [PAYLOAD_BITS-1:0] payload;
        logic error;
    } sys_state_type;

    sys_state_type s;
    sys_state_type next_s;

    logic [FRAME_BITS-1:0] frameWord;
    logic frameToggle;
    logic extraToggle;
    logic selectRise;
    logic gotFrame;
    logic gotExtra;
    logic crcOk;

    // ========================================================================
    // Link-clock engine
    // ========================================================================
    // Held reply changes while synced select is high, so up to two cycles into a frame
    spi_link_shifter linkShifter (
        .rst(rst),
        .shiftClock(shiftClock),
        .frameSelectLow(frameSelectLow),
        .mosi(mosi),
        .misoOut(misoOut),
        .txWord(s.txHeld),
        .frameWord(frameWord),
        .frameToggle(frameToggle),
        .extraToggle(extraToggle)
    );

    // Driven only while selected, shared bus otherwise
    assign misoOe = ~frameSelectLow;

    // ========================================================================
    // Frame evaluation
    // ========================================================================
    // Toggle compare tells whether exactly 24 bits arrived in this frame
    assign selectRise = s.selSync & ~s.selPrev;
    assign gotFrame = s.frameSync != s.frameSeen;
    assign gotExtra = s.extraSync != s.extraSeen;
    // Whole frame including check bits must leave a zero remainder
    assign crcOk = check_remainder(frameWord) == CRC_GOOD;

    always_comb begin
        next_s = s;
        // Pin and toggle synchronisers, two stages each
        next_s.selMeta = frameSelectLow;
        next_s.selSync = s.selMeta;
        next_s.selPrev = s.selSync;
        next_s.frameMeta = frameToggle;
        next_s.frameSync = s.frameMeta;
        next_s.extraMeta = extraToggle;
        next_s.extraSync = s.extraMeta;
        next_s.valid = 1'b0;
        next_s.error = 1'b0;
        // Reply built from live status while idle, frozen two cycles after select falls
        // Only the second sync stage is read; a status change in that gap can tear
        // the reply, which its check code then exposes to the master
        if (s.selSync) begin
            next_s.txHeld = {txPayload, check_remainder({txPayload, CRC_GOOD})};
        end
        // Select rise: the frame word is stable since the link clock stopped
        if (selectRise) begin
            next_s.frameSeen = s.frameSync;
            next_s.extraSeen = s.extraSync;
            if (gotFrame && !gotExtra && crcOk) begin
                next_s.valid = 1'b1;
                next_s.payload = frameWord[FRAME_BITS-1:PAYLOAD_LSB];
            end else begin
                next_s.error = 1'b1; // short, long or bad check code
            end
        end
    end

    // Clock enable low freezes every system-domain flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{selMeta: 1'b1, selSync: 1'b1, selPrev: 1'b1, default: '0};
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign rxValid = s.valid;
    assign rxPayload = s.payload;
    assign commError = s.error;

endmodule : gate_driver_spi_slave_crc

// *** common/gd_spi_pkg.sv ***
// Shared constants and the check-code function of the gate driver serial slave.
// Assumes nothing of its surroundings; imported by both design files.
package gd_spi_pkg;

    // ========================================================================
    // Frame layout
    // ========================================================================
    localparam int FRAME_BITS = 24;
    localparam int CRC_BITS = 3;
    localparam int PAYLOAD_BITS = FRAME_BITS - CRC_BITS;
    localparam int COUNT_BITS = 5;
    // Check code sits in the lowest bits, payload above it
    localparam int CRC_LSB = 0;
    localparam int PAYLOAD_LSB = CRC_BITS;

    // Bit counter values: last frame bit and first bit beyond the frame
    localparam logic [COUNT_BITS-1:0] COUNT_LAST = 5'h17;
    localparam logic [COUNT_BITS-1:0] COUNT_OVER = 5'h18;
    localparam logic [COUNT_BITS-1:0] COUNT_ZERO = 5'h00;

    // ========================================================================
    // Check code: x^3 + x^1 + 1, register seeded 101, start value 100
    // ========================================================================
    localparam logic [CRC_BITS-1:0] CRC_POLY = 3'h3;
    localparam logic [CRC_BITS-1:0] CRC_SEED = 3'h5;
    localparam logic [CRC_BITS-1:0] CRC_START = 3'h4;
    localparam logic [CRC_BITS-1:0] CRC_GOOD = 3'h0;

    // Serial remainder over a whole frame, most significant bit first
    function automatic logic [CRC_BITS-1:0] check_remainder(input logic [FRAME_BITS-1:0] word);
        logic [CRC_BITS-1:0] r;
        logic fb;
        r = CRC_START;
        fb = 1'b0;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            fb = r[CRC_BITS-1];
            r = {r[CRC_BITS-2:0], word[i]};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction : check_remainder

endpackage : gd_spi_pkg

// *** core/spi_link_shifter.sv ***
// Link-side shift engine, clocked by the master's shift clock.
// Assumes the shift clock idles low and only toggles while select is low.
`timescale 1ns/1ps
module spi_link_shifter (
    // Resets and link clock
    input wire logic rst,
    input wire logic shiftClock,
    input wire logic frameSelectLow,
    // Serial data
    input wire logic mosi,
    output logic misoOut,
    // Toward the system domain
    input wire logic [gd_spi_pkg::FRAME_BITS-1:0] txWord,
    output logic [gd_spi_pkg::FRAME_BITS-1:0] frameWord,
    output logic frameToggle,
    output logic extraToggle
);
    import gd_spi_pkg::*;

    // ========================================================================
    // Receive side, rising edge
    // ========================================================================
    typedef struct packed {
        logic [FRAME_BITS-1:0] shift;
        logic [FRAME_BITS-1:0] word;
        logic frameT;
        logic extraT;
    } rx_state_type;

    rx_state_type rx;
    rx_state_type next_rx;
    logic [COUNT_BITS-1:0] rxCount;
    logic [COUNT_BITS-1:0] txCount;
    logic [FRAME_BITS-1:0] txShift;
    logic frameIdle;

    // Select high ends the frame: counters clear without needing a clock edge
    assign frameIdle = rst | frameSelectLow;

    // Shift in MSB first; capture the word on the last bit
    always_comb begin
        next_rx = rx;
        next_rx.shift = {rx.shift[FRAME_BITS-2:0], mosi};
        if (rxCount == COUNT_LAST) begin
            next_rx.word = {rx.shift[FRAME_BITS-2:0], mosi};
            next_rx.frameT = ~rx.frameT;
        end else if (rxCount == COUNT_OVER) begin
            next_rx.extraT = ~rx.extraT; // too many bits, flagged once
        end
    end

    always_ff @(posedge shiftClock or posedge rst) begin
        if (rst) begin
            rx <= '0;
        end else begin
            rx <= next_rx;
        end
    end

    // Bit counter saturates one past COUNT_OVER
    always_ff @(posedge shiftClock or posedge frameIdle) begin
        if (frameIdle) begin
            rxCount <= COUNT_ZERO;
        end else if (rxCount != COUNT_OVER + 5'h01) begin
            rxCount <= rxCount + 5'h01;
        end
    end

    // ========================================================================
    // Transmit side, falling edge
    // ========================================================================
    // First bit is shown straight from the held word before any clock edge
    always_ff @(negedge shiftClock or posedge frameIdle) begin
        if (frameIdle) begin
            txCount <= COUNT_ZERO;
            txShift <= '0;
        end else begin
            txShift <= (txCount == COUNT_ZERO) ? (txWord << 1) : (txShift << 1);
            if (txCount != COUNT_OVER) begin
                txCount <= txCount + 5'h01;
            end
        end
    end

    // Own reply word only, never the received bits
    assign misoOut = (txCount == COUNT_ZERO) ? txWord[FRAME_BITS-1] : txShift[FRAME_BITS-1];
    assign frameWord = rx.word;
    assign frameToggle = rx.frameT;
    assign extraToggle = rx.extraT;

endmodule : spi_link_shifter

// *** verif/gd_spi_props.sv ***
// Port checker for the gate driver serial slave.
// Assumes select idles high and the system clock runs throughout.
`timescale 1ns/1ps
module gd_spi_props (
    // System side
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Link pins
    input wire logic shiftClock,
    input wire logic frameSelectLow,
    input wire logic mosi,
    input wire logic misoOut,
    input wire logic misoOe,
    // User side
    input wire logic [gd_spi_pkg::PAYLOAD_BITS-1:0] txPayload,
    input wire logic rxValid,
    input wire logic [gd_spi_pkg::PAYLOAD_BITS-1:0] rxPayload,
    input wire logic commError
);
    import gd_spi_pkg::*;
    // ========================================================================
    // Assertions, all on the system clock
    // ========================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_oe_follow: assert property (misoOe == !frameSelectLow)
        else $error("output enable does not follow select");
    chk_frame_quiet: assert property ((!frameSelectLow)[*5] |-> !rxValid && !commError)
        else $error("result while frame still open");
    chk_result_bounded: assert property ($rose(frameSelectLow) |-> ##[2:5] (rxValid || commError))
        else $error("no result after select rise");
    chk_result_exclusive: assert property (!(rxValid && commError))
        else $error("valid and error together");
    chk_payload_held: assert property ($changed(rxPayload) |-> rxValid)
        else $error("payload changed without good frame");
    chk_valid_single: assert property (rxValid |=> !rxValid)
        else $error("valid longer than one cycle");
    chk_error_single: assert property (commError |=> !commError)
        else $error("error longer than one cycle");
    chk_idle_quiet: assert property (frameSelectLow[*8] |=> !rxValid && !commError)
        else $error("result with no frame");
    // Main scenarios
    cov_good: cover property (rxValid);
    cov_bad: cover property (commError);
    cov_frame: cover property ($rose(frameSelectLow));
endmodule : gd_spi_props

bind gate_driver_spi_slave_crc gd_spi_props props_u (.clock(clock), .rst(rst), .ce(ce),
    .shiftClock(shiftClock), .frameSelectLow(frameSelectLow), .mosi(mosi), .misoOut(misoOut),
    .misoOe(misoOe), .txPayload(txPayload), .rxValid(rxValid), .rxPayload(rxPayload), .commError(commError));

// *** verif/spi_master_model.sv ***
// Behavioural serial master: 30 ns shift clock, runs only within frames.
// Assumes the slave answers on its data line while enabled.
`timescale 1ns/1ps
module spi_master_model (
    // Link outputs
    output logic shiftClock,
    output logic frameSelectLow,
    output logic mosi,
    // Slave answer
    input wire logic misoOut,
    input wire logic misoOe
);
    // ========================================================================
    // Frame task; clock idles low, data line pulled low outside frames
    // ========================================================================
    initial begin
        shiftClock = 1'b0;
        frameSelectLow = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input logic [23:0] w, input int nb, output logic [23:0] got);
        frameSelectLow = 1'b0;
        #40;
        for (int i = 0; i < nb; i++) begin
            mosi = (i < 24) ? w[23-i] : 1'b0;
            #15 shiftClock = 1'b1;
            if (i < 24) got[23-i] = misoOe ? misoOut : 1'b0;
            #15 shiftClock = 1'b0;
        end
        #30 frameSelectLow = 1'b1;
        mosi = 1'b0; // Pull-down level once released
    endtask : xfer
endmodule : spi_master_model

// *** verif/gate_driver_spi_slave_crc_tb_top.sv ***
// Self-checking bench: good, bad-code, short and long frames.
// Assumes the serial master model drives the link pins.
`timescale 1ns/1ps
module gate_driver_spi_slave_crc_tb_top;
    import gd_spi_pkg::*;
    typedef struct packed {logic bad; logic [PAYLOAD_BITS-1:0] pay;} note_type;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic shiftClock, frameSelectLow, mosi, misoOut, misoOe, rxValid, commError;
    logic [PAYLOAD_BITS-1:0] txPayload = '0;
    logic [PAYLOAD_BITS-1:0] rxPayload;
    note_type notes[$];
    int errors = 0;
    int num_checks = 0;
    int seed = 42061;
    // ========================================================================
    // Clock, design, far side
    // ========================================================================
    always #25 clock = ~clock;
    gate_driver_spi_slave_crc dut_u (.clock(clock), .rst(rst), .ce(ce), .shiftClock(shiftClock),
        .frameSelectLow(frameSelectLow), .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe),
        .txPayload(txPayload), .rxValid(rxValid), .rxPayload(rxPayload), .commError(commError));
    spi_master_model master_u (.shiftClock(shiftClock), .frameSelectLow(frameSelectLow), .mosi(mosi),
        .misoOut(misoOut), .misoOe(misoOe));
    // Own serial check code, start value 100, polynomial 011
    function automatic logic [2:0] ref_crc(input logic [23:0] w);
        logic [2:0] r;
        logic fb;
        r = 3'h4;
        for (int i = 23; i >= 0; i--) begin
            fb = r[2];
            r = {r[1:0], w[i]} ^ (fb ? 3'h3 : 3'h0);
        end
        return r;
    endfunction : ref_crc
    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t reply %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_result(input note_type got, input note_type exp);
        num_checks++;
        if (got.bad !== exp.bad || (!exp.bad && got.pay !== exp.pay)) begin
            errors++;
            $display("[FAIL] %0t result %h expected %h", $time, got, exp);
        end
    endtask : chk_result
    // Kind 0 good, 1 bad code, 2 short, 3 long; new live status each frame
    task automatic run_frame(input int kind);
        logic [23:0] w;
        logic [23:0] got;
        note_type n;
        int nb;
        @(posedge clock);
        txPayload <= PAYLOAD_BITS'($random(seed));
        repeat (4) @(posedge clock);
        w = 24'($random(seed));
        w[2:0] = ref_crc({w[23:3], 3'h0});
        if (kind == 1) w[0] = ~w[0];
        nb = (kind == 2) ? 23 : (kind == 3) ? 25 : 24;
        n.bad = (kind != 0);
        n.pay = w[23:3];
        notes.push_back(n);
        master_u.xfer(w, nb, got);
        // Bad reply code: master drops the reply and repeats the same access
        if (nb == 24 && ref_crc(got) != 3'h0) begin
            repeat (8) @(posedge clock);
            notes.push_back(n);
            master_u.xfer(w, nb, got);
        end
        if (nb == 24) chk_word(got, {txPayload, ref_crc({txPayload, 3'h0})});
        repeat (8) @(posedge clock);
        // Enable dropped while idle; later frames must still decode
        if (kind == 3) begin
            ce <= 1'b0;
            repeat (3) @(posedge clock);
            ce <= 1'b1;
        end
    endtask : run_frame
    // Result watcher takes the oldest note
    always @(posedge clock) begin
        if (!rst && (rxValid === 1'b1 || commError === 1'b1)) begin
            if (notes.size() == 0) chk_result({commError, rxPayload}, {~commError, rxPayload});
            else chk_result({commError, rxPayload}, notes.pop_front());
        end
    end
    task automatic summarize();
        if (notes.size() != 0) errors++;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        #500000;
        errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        for (int k = 0; k < 24; k++) run_frame(k % 4);
        repeat (10) @(posedge clock);
        summarize();
    end
endmodule : gate_driver_spi_slave_crc_tb_top
